// ### shared/lcr_pkg.sv
// Package: offsets, field layouts and reset values of the lookup config bank
package lcr_pkg;
  localparam logic [7:0] LCR_OFF_SIZE = 8'h01;
  localparam logic [7:0] LCR_OFF_AGE_LO = 8'h02;
  localparam logic [7:0] LCR_OFF_AGE_HI = 8'h03;
  localparam logic [7:0] LCR_OFF_UNK_LO = 8'h04;
  localparam logic [7:0] LCR_OFF_UNK_HI = 8'h05;
  localparam int LCR_SIZE_CODE_MSB = 3;
  localparam logic [3:0] LCR_SIZE_CODE_MAX = 4'hC;
  localparam logic [7:0] LCR_SIZE_RST = 8'h00;
  localparam logic [15:0] LCR_AGE_RST = 16'h0000;
  localparam logic [15:0] LCR_AGE_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] LCR_UNK_RST = 16'h7FFF;
  localparam logic [15:0] LCR_UNK_USED = 16'h7FFF;
  localparam int LCR_EE_BYTES = 5;
  localparam int LCR_CLK_HZ = 200000000;
  typedef enum {LCR_IDLE, LCR_LOAD} lcr_state_type;
endpackage : lcr_pkg

// ### shared/lcr_ee_if.sv
// Interface: byte stream from the EEPROM image reader to the register bank
`timescale 1ns/1ps
interface lcr_ee_if;
  logic req;
  logic [2:0] idx;
  logic vld;
  logic [7:0] data;
  logic done;
  modport bank (output req, input idx, input vld, input data, input done);
  modport loader (input req, output idx, output vld, output data,
    output done);
endinterface : lcr_ee_if

// ### rtl/lcr_ee_loader.sv
// Sequencer handing EEPROM image bytes to the bank, one per cycle
`timescale 1ns/1ps
module lcr_ee_loader
  import lcr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_ee_byte,
  output logic [2:0] o_ee_addr,
  lcr_ee_if.loader ee
);
  lcr_state_type state_q;
  logic [2:0] idx_q;

  // Image memory is outside; its byte at o_ee_addr is read combinationally
  assign o_ee_addr = idx_q;
  assign ee.idx = idx_q;
  assign ee.data = i_ee_byte;
  assign ee.vld = (state_q == LCR_LOAD);
  assign ee.done = (state_q == LCR_LOAD) &&
    (idx_q == 3'(LCR_EE_BYTES - 1));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= LCR_IDLE;
      idx_q <= 3'h0;
    end else begin
      case (state_q)
        LCR_IDLE: begin
          idx_q <= 3'h0;
          if (ee.req) begin
            state_q <= LCR_LOAD;
          end
        end
        LCR_LOAD: begin
          if (ee.done) begin
            state_q <= LCR_IDLE;
            idx_q <= 3'h0;
          end else begin
            idx_q <= idx_q + 3'h1;
          end
        end
        default: state_q <= LCR_IDLE;
      endcase
    end
  end
endmodule : lcr_ee_loader

// ### rtl/lcr_bank.sv
// Lookup configuration register bank with autoload and mask application
// Notes on behaviour
// - Size register writes only accepted while soft reset bit is 0.
// - Size register reloads from image on hard reset or load request.
// - Size code bits 3..0 pick SRAM organisation, codes 0 to C.
// - Size code steers table count and SRAM address lines at init.
// - Age threshold zero or all ones selects table-full aging.
// - Other thresholds select threshold aging in seconds.
// - Aging never removes secured or multicast entries.
// - Manual table management bit disables all aging.
// - Age threshold fully read/write, resets zero, reloads from image.
// - Unknown unicast goes only to masked ports.
// - Each mask application pulses the flood counter increment.
// - Source port bit cleared from applied mask.
// - Mask bit n is port n; bit 15 reserved.
// - Mask read/write and reloaded from image.
// - Soft reset returns size, age and mask registers to reset values (mask 7FFF).
// - Load request starts autoload; loader clears it on completion.
`timescale 1ns/1ps
module lcr_bank
  import lcr_pkg::*;
#(
  parameter int PORTS = 15
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_soft_reset,
  input wire logic i_load_req,
  output logic o_load_busy,
  input wire logic i_manual_table_management,
  input wire logic [7:0] i_ee_byte,
  output logic [2:0] o_ee_addr,
  output logic [3:0] o_sram_size_code,
  output logic o_size_valid,
  output logic o_table_full_aging,
  output logic o_threshold_aging,
  output logic [15:0] o_age_seconds,
  input wire logic i_entry_secured,
  input wire logic i_entry_multicast,
  output logic o_entry_agable,
  input wire logic i_miss,
  input wire logic [3:0] i_src_port,
  output logic [PORTS-1:0] o_fwd_mask,
  output logic o_flood_inc
);
  if (PORTS < 1 || PORTS > 15) begin : g_ports_check
    $error("PORTS must be 1 to 15");
  end

  lcr_ee_if ee ();
  logic [7:0] size_q;
  logic [15:0] age_q;
  logic [15:0] unk_q;
  logic load_q;
  logic [PORTS-1:0] fwd_q;
  logic flood_q;

  lcr_ee_loader u_loader (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ee_byte(i_ee_byte),
    .o_ee_addr(o_ee_addr),
    .ee(ee)
  );

  // Reset release counts as a hard reset load request
  // Done outranks a request in its cycle; a request held past done starts another load
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      load_q <= 1'b1;
    end else if (i_soft_reset) begin
      load_q <= 1'b0;
    end else if (ee.done) begin
      load_q <= 1'b0;
    end else if (i_load_req) begin
      load_q <= 1'b1;
    end
  end
  assign o_load_busy = load_q;
  // Pulse request once; loader ignores it while already loading
  assign ee.req = load_q && !ee.vld;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      size_q <= LCR_SIZE_RST;
      age_q <= LCR_AGE_RST;
      unk_q <= LCR_UNK_RST;
    end else if (i_soft_reset) begin
      size_q <= LCR_SIZE_RST;
      age_q <= LCR_AGE_RST;
      unk_q <= LCR_UNK_RST;
    end else if (ee.vld) begin
      // Host writes are locked out while the image streams in
      case (ee.idx)
        3'h0: size_q <= {4'h0, ee.data[LCR_SIZE_CODE_MSB:0]};
        3'h1: age_q[7:0] <= ee.data;
        3'h2: age_q[15:8] <= ee.data;
        3'h3: unk_q[7:0] <= ee.data;
        3'h4: unk_q[15:8] <= {1'b0, ee.data[6:0]};
        default: ;
      endcase
    end else if (i_wr) begin
      case (i_addr)
        LCR_OFF_SIZE: size_q <= {4'h0, i_wdata[3:0]};
        LCR_OFF_AGE_LO: age_q[7:0] <= i_wdata;
        LCR_OFF_AGE_HI: age_q[15:8] <= i_wdata;
        LCR_OFF_UNK_LO: unk_q[7:0] <= i_wdata;
        LCR_OFF_UNK_HI: unk_q[15:8] <= {1'b0, i_wdata[6:0]};
        default: ;
      endcase
    end
  end

  always_comb begin
    case (i_addr)
      LCR_OFF_SIZE: o_rdata = size_q;
      LCR_OFF_AGE_LO: o_rdata = age_q[7:0];
      LCR_OFF_AGE_HI: o_rdata = age_q[15:8];
      LCR_OFF_UNK_LO: o_rdata = unk_q[7:0];
      LCR_OFF_UNK_HI: o_rdata = unk_q[15:8];
      default: o_rdata = 8'h00;
    endcase
  end

  assign o_sram_size_code = size_q[LCR_SIZE_CODE_MSB:0];
  assign o_size_valid = (size_q[3:0] <= LCR_SIZE_CODE_MAX);
  assign o_table_full_aging = !i_manual_table_management &&
    (age_q == LCR_AGE_RST || age_q == LCR_AGE_ALL_ONES);
  assign o_threshold_aging = !i_manual_table_management &&
    !(age_q == LCR_AGE_RST || age_q == LCR_AGE_ALL_ONES);
  assign o_age_seconds = age_q;
  assign o_entry_agable = !i_manual_table_management && !i_entry_secured &&
    !i_entry_multicast;

  // Registered so the switch sees a stable mask for a whole cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fwd_q <= '0;
      flood_q <= 1'b0;
    end else begin
      flood_q <= i_miss;
      if (i_miss) begin
        fwd_q <= unk_q[PORTS-1:0] &
          ~(PORTS'(1) << i_src_port);
      end
    end
  end
  assign o_fwd_mask = fwd_q;
  assign o_flood_inc = flood_q;

  property p_flood;
    @(posedge i_clk) disable iff (i_rst) i_miss |=> o_flood_inc;
  endproperty
  a_flood: assert property (p_flood) else $error("flood pulse missing");

  property p_src;
    @(posedge i_clk) disable iff (i_rst)
      i_miss && i_src_port < 4'(PORTS) |=> !o_fwd_mask[$past(i_src_port)];
  endproperty
  a_src: assert property (p_src) else $error("source port forwarded");

  property p_mask;
    @(posedge i_clk) disable iff (i_rst)
      i_miss |=> (o_fwd_mask & ~$past(unk_q[PORTS-1:0])) == '0;
  endproperty
  a_mask: assert property (p_mask) else $error("mask escaped");

  property p_resv;
    @(posedge i_clk) disable iff (i_rst) size_q[7:4] == 4'h0 && !unk_q[15];
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");

  property p_soft;
    @(posedge i_clk) disable iff (i_rst)
      i_soft_reset |=> size_q == LCR_SIZE_RST && age_q == LCR_AGE_RST &&
        unk_q == LCR_UNK_RST;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset missed");

  property p_load_clr;
    @(posedge i_clk) disable iff (i_rst)
      ee.done && !i_soft_reset |=> !load_q;
  endproperty
  a_load_clr: assert property (p_load_clr) else $error("load kept");

  property p_load_end;
    @(posedge i_clk) disable iff (i_rst)
      $rose(ee.vld) |-> ##4 ee.done;
  endproperty
  a_load_end: assert property (p_load_end) else $error("load length");

  property p_load_start;
    @(posedge i_clk) disable iff (i_rst)
      load_q && !ee.vld |=> ee.vld;
  endproperty
  a_load_start: assert property (p_load_start) else $error("no load");

  property p_age_mode;
    @(posedge i_clk) disable iff (i_rst)
      i_manual_table_management ? !(o_table_full_aging || o_threshold_aging)
        : (o_table_full_aging != o_threshold_aging);
  endproperty
  a_age_mode: assert property (p_age_mode) else $error("aging mode");

  property p_wr_age;
    @(posedge i_clk) disable iff (i_rst)
      i_wr && !ee.vld && !i_soft_reset && i_addr == LCR_OFF_AGE_LO
      |=> age_q[7:0] == $past(i_wdata);
  endproperty
  a_wr_age: assert property (p_wr_age) else $error("age write lost");
endmodule : lcr_bank

// ### dv/lcr_ee_image.sv
// Model of the EEPROM image memory behind the autoloader
`timescale 1ns/1ps
module lcr_ee_image (
  input wire logic [2:0] i_addr,
  input wire logic [39:0] i_image,
  output logic [7:0] o_byte
);
  // Past the image a changing pattern, so stale data never matches
  always_comb begin
    if (i_addr < 3'h5) o_byte = i_image[i_addr*8 +: 8];
    else o_byte = {5'h15, i_addr};
  end
endmodule : lcr_ee_image

// ### dv/lcr_bank_test.sv
// Self-checking testbench of the lookup config register bank
`timescale 1ns/1ps
module lcr_bank_test;
  import lcr_pkg::*;
  logic clk = 0, rst = 1, wr = 0, srst = 0, ldr = 0, man = 0;
  logic sec = 0, mc = 0, miss = 0, busy, size_ok, full_ag, thr_ag;
  logic agable, flood;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, ee_byte;
  logic [3:0] src = 4'h0, code;
  logic [2:0] ee_addr;
  logic [39:0] image;
  logic [15:0] age_s, ag, mk;
  logic [14:0] fwd;
  int miscompares = 0, checks = 0;
  lcr_bank lcr_bank_inst (.i_clk(clk), .i_rst(rst), .i_wr(wr),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
    .i_soft_reset(srst), .i_load_req(ldr), .o_load_busy(busy),
    .i_manual_table_management(man), .i_ee_byte(ee_byte),
    .o_ee_addr(ee_addr), .o_sram_size_code(code), .o_size_valid(size_ok),
    .o_table_full_aging(full_ag), .o_threshold_aging(thr_ag),
    .o_age_seconds(age_s), .i_entry_secured(sec),
    .i_entry_multicast(mc), .o_entry_agable(agable), .i_miss(miss),
    .i_src_port(src), .o_fwd_mask(fwd), .o_flood_inc(flood));
  lcr_ee_image lcr_ee_image_inst (.i_addr(ee_addr), .i_image(image),
    .o_byte(ee_byte));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic complete_run();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_b
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
  endtask : rd_chk
  task automatic regs_chk(input logic [7:0] s, input logic [15:0] a,
    input logic [15:0] m);
    rd_chk(LCR_OFF_SIZE, s & 8'h0F);
    rd_chk(LCR_OFF_AGE_LO, a[7:0]);
    rd_chk(LCR_OFF_AGE_HI, a[15:8]);
    rd_chk(LCR_OFF_UNK_LO, m[7:0]);
    rd_chk(LCR_OFF_UNK_HI, m[15:8] & 8'h7F);
  endtask : regs_chk
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (busy !== 1'b0) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, busy, 1'b0);
      complete_run();
    end
  endtask : wait_idle
  function automatic logic [14:0] exp_fwd(logic [15:0] m, logic [3:0] s);
    logic [14:0] r;
    r = m[14:0];
    if (s < 4'hF) r[s] = 1'b0;
    return r;
  endfunction : exp_fwd
  initial begin
    void'($urandom(99));
    image = {8'hFF, $urandom()};
    repeat (1) @(negedge clk);
    regs_chk(8'h00, 16'h0000, 16'h7FFF);
    rst = 1'b0;
    wait_idle();
    regs_chk(image[7:0], image[23:8], image[39:24]);
    $display("test reset and autoload done");
    for (int k = 0; k < 16; k++) begin
      wr_b(LCR_OFF_SIZE, 8'hF0 | 8'(k));
      chk({11'h000, size_ok, code}, {11'h000, k <= 12, 4'(k)});
    end
    for (int i = 0; i < 8; i++) begin
      ag = (i < 2) ? {16{i[0]}} : 16'($urandom());
      mk = (i == 2) ? 16'hFFFF : 16'($urandom());
      man = i[2];
      wr_b(LCR_OFF_AGE_LO, ag[7:0]);
      wr_b(LCR_OFF_AGE_HI, ag[15:8]);
      wr_b(LCR_OFF_UNK_LO, mk[7:0]);
      wr_b(LCR_OFF_UNK_HI, mk[15:8]);
      regs_chk(8'h0F, ag, mk);
      chk(age_s, ag);
      chk({full_ag, thr_ag}, {(ag == 0 || &ag) && !man,
        !(ag == 0 || &ag) && !man});
      {sec, mc} = 2'(i);
      #1;
      chk(agable, !(sec | mc | man));
      @(negedge clk);
      miss = 1'b1;
      src = (i == 0) ? 4'h0 : (i == 1) ? 4'hE : 4'($urandom_range(14));
      @(negedge clk);
      miss = 1'b0;
      chk({flood, fwd}, {1'b1, exp_fwd(mk, src)});
      @(negedge clk);
      chk(flood, 1'b0);
    end
    $display("test writes, aging and miss done");
    srst = 1'b1;
    wr_b(LCR_OFF_SIZE, 8'h05);
    srst = 1'b0;
    regs_chk(8'h00, 16'h0000, 16'h7FFF);
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h06, 8'h00);
    $display("test soft reset done");
    image = {$urandom(), 8'h07};
    ldr = 1'b1;
    @(negedge clk);
    ldr = 1'b0;
    @(negedge clk);
    chk(busy, 1'b1);
    wait_idle();
    regs_chk(image[7:0], image[23:8], image[39:24]);
    $display("test load request done");
    complete_run();
  end
endmodule : lcr_bank_test
